// File: include/sci_defines.svh
`ifndef SCI_DEFINES_SVH
`define SCI_DEFINES_SVH
// Register byte addresses
`define SCI_A_CTRL     8'h00
`define SCI_A_MODE     8'h04
`define SCI_A_LOOPS    8'h08
`define SCI_A_SEGLEN   8'h0c
`define SCI_A_SWIDX    8'h10
`define SCI_A_STATUS   8'h14
`define SCI_A_INDEX    8'h18
// Control register bits
`define SCI_B_RUN      0
`define SCI_B_STOP     1
`define SCI_B_SWTRIG   2
`define SCI_B_SWENA    3
`define SCI_B_SWEVT    4
`define SCI_B_HWDIS    5
// Mode register fields
`define SCI_F_TMODE    1:0
`define SCI_B_ARMED    2
`define SCI_F_ADV      5:4
// Index layout
`define SCI_IDX_W      19
`define SCI_LO_W       13
`define SCI_HI_W       6
// Reset values
`define SCI_RST_LOOPS  16'h0001
`define SCI_RST_SEGLEN 16'h0010
`define SCI_RST_MODE   6'h00
// Bus answers
`define SCI_RESP_OK    2'h0
`define SCI_RESP_ERR   2'h2
`endif

// File: include/sci_pkg.sv
package sci_pkg;
  typedef enum logic [1:0] {
    SCI_TRG_CONT = 2'b00,
    SCI_TRG_TRIG = 2'b01,
    SCI_TRG_GATE = 2'b10
  } sci_trig_t;
  typedef enum logic [1:0] {
    SCI_ADV_AUTO = 2'b00,
    SCI_ADV_COND = 2'b01,
    SCI_ADV_REPT = 2'b10,
    SCI_ADV_SNGL = 2'b11
  } sci_adv_t;
  typedef enum logic [2:0] {
    SCI_ST_PROG = 3'b000,
    SCI_ST_OFFS = 3'b001,
    SCI_ST_PLAY = 3'b010,
    SCI_ST_WEVT = 3'b011,
    SCI_ST_HOLD = 3'b100
  } sci_state_t;
  typedef enum logic [1:0] {
    SCI_OUT_OFFSET = 2'b00,
    SCI_OUT_SAMPLE = 2'b01,
    SCI_OUT_LAST   = 2'b10
  } sci_out_t;
  typedef struct packed {
    sci_adv_t  adv;
    logic      armed;
    sci_trig_t tmode;
  } sci_mode_t;
  typedef struct packed {
    logic        sel;
    logic        load;
    logic [12:0] data;
  } sci_port_t;
endpackage

// File: core/sci_ctrl_inputs.sv
// Chosen here: the register offsets and the AXI4-Lite register port.
`include "sci_defines.svh"
`default_nettype none
module sci_ctrl_inputs
  import sci_pkg::*;
#(
  parameter int DAC_BITS = 14,
  parameter int CNT_W    = 16
)(
  input  wire logic                  MCLK,
  input  wire logic                  SYS_RST,
  input  wire logic [7:0]            S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [7:0]            S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  input  wire logic [12:0]           IDX_DATA,
  input  wire logic                  IDX_SEL,
  input  wire logic                  IDX_LOAD,
  input  wire logic                  TRIG_GATE_IN,
  input  wire logic                  EVENT_IN,
  output logic [`SCI_IDX_W-1:0]      SEQ_INDEX,
  output logic                       SEQ_INDEX_STB,
  output logic [1:0]                 OUT_SEL,
  output logic [DAC_BITS-1:0]        OFFSET_CODE,
  output logic [CNT_W-1:0]           SEG_POS,
  output logic                       RUNNING
);
  // Mid-scale code: (max - min) / 2 with min code zero
  localparam logic [DAC_BITS-1:0] DAC_MAX = {DAC_BITS{1'b1}};
  localparam logic [DAC_BITS-1:0] MID_CODE = DAC_MAX >> 1;

  // Register state
  sci_mode_t              mode_q;
  logic [CNT_W-1:0]       loops_q;
  logic [CNT_W-1:0]       seglen_q;
  logic                   sw_ena_q;
  logic                   hw_dis_q;
  logic                   sw_prec_q;
  logic [`SCI_IDX_W-1:0]  sw_idx_q;
  logic [`SCI_HI_W-1:0]   hi_q;
  logic [`SCI_LO_W-1:0]   lo_q;
  logic [`SCI_IDX_W-1:0]  hw_idx_q;
  logic [`SCI_IDX_W-1:0]  idx_q;
  logic                   idx_stb_q;
  // Bus state
  logic                   aw_hold_q;
  logic                   w_hold_q;
  logic [7:0]             awaddr_q;
  logic [31:0]            wdata_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   rvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;
  // Port synchronisers
  sci_port_t              port_s1_q;
  sci_port_t              port_s2_q;
  logic                   load_prev_q;
  logic                   trig_prev_q;
  // Sequencer state
  sci_state_t             state_q;
  logic [CNT_W-1:0]       pos_q;
  logic [CNT_W-1:0]       pass_q;
  logic                   evt_q;
  logic                   arm_wait_q;
  logic                   gate_stop_q;
  logic [1:0]             out_sel_q;

  // Write channel: address and data accepted in either order
  wire wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_ctrl = wr_go && (awaddr_q == `SCI_A_CTRL);
  wire wr_mode = wr_go && (awaddr_q == `SCI_A_MODE);
  wire wr_lps  = wr_go && (awaddr_q == `SCI_A_LOOPS);
  wire wr_len  = wr_go && (awaddr_q == `SCI_A_SEGLEN);
  wire wr_swi  = wr_go && (awaddr_q == `SCI_A_SWIDX);
  wire wr_hit  = wr_ctrl || wr_mode || wr_lps || wr_len || wr_swi;
  assign S_AXI_AWREADY = !aw_hold_q;
  assign S_AXI_WREADY  = !w_hold_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  // Byte lane merge for writes; unchanged lanes keep old contents
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Mode word into its fields; bit 3 of the word is unused
  function automatic sci_mode_t mode_of(input logic [5:0] w);
    sci_mode_t m;
    m.adv   = sci_adv_t'(w[`SCI_F_ADV]);
    m.armed = w[`SCI_B_ARMED];
    m.tmode = sci_trig_t'(w[`SCI_F_TMODE]);
    return m;
  endfunction

  logic [3:0] wstrb_q;
  wire [31:0] ctrl_old = {26'h0, hw_dis_q, 1'b0, sw_ena_q, 3'h0};
  wire [31:0] ctrl_new = merge(ctrl_old, wdata_q, wstrb_q);
  wire [31:0] mode_rd  = {26'h0, mode_q.adv, 1'b0, mode_q.armed,
                          mode_q.tmode};
  wire [31:0] mode_new = merge(mode_rd, wdata_q, wstrb_q);
  wire [31:0] lps_new  = merge({{(32-CNT_W){1'b0}}, loops_q}, wdata_q,
                               wstrb_q);
  wire [31:0] len_new  = merge({{(32-CNT_W){1'b0}}, seglen_q}, wdata_q,
                               wstrb_q);
  wire [31:0] swi_new  = merge({13'h0, sw_idx_q}, wdata_q, wstrb_q);

  // Software command pulses, only on a real write to control
  wire sw_run  = wr_ctrl && ctrl_new[`SCI_B_RUN];
  wire sw_stop = wr_ctrl && ctrl_new[`SCI_B_STOP];
  wire sw_trig = wr_ctrl && ctrl_new[`SCI_B_SWTRIG];
  wire sw_evt  = wr_ctrl && ctrl_new[`SCI_B_SWEVT];

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SCI_RESP_OK;
    end
    else
    begin
      if (S_AXI_AWVALID && !aw_hold_q)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_hold_q)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= S_AXI_WDATA;
        wstrb_q  <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `SCI_RESP_OK : `SCI_RESP_ERR;
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
      end
      else if (bvalid_q && S_AXI_BREADY)
        bvalid_q <= 1'b0;
    end
  end

  // Register file
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      mode_q    <= mode_of(`SCI_RST_MODE);
      loops_q   <= CNT_W'(`SCI_RST_LOOPS);
      seglen_q  <= CNT_W'(`SCI_RST_SEGLEN);
      sw_ena_q  <= 1'b0;
      hw_dis_q  <= 1'b0;
      sw_idx_q  <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        sw_ena_q <= ctrl_new[`SCI_B_SWENA];
        hw_dis_q <= ctrl_new[`SCI_B_HWDIS];
      end
      if (wr_mode)
        mode_q <= mode_of(mode_new[5:0]);
      if (wr_lps)
        loops_q <= lps_new[CNT_W-1:0];
      if (wr_len)
        seglen_q <= len_new[CNT_W-1:0];
      if (wr_swi)
        sw_idx_q <= swi_new[`SCI_IDX_W-1:0];
    end
  end

  // Read path, one cycle after the address is taken
  wire [7:0] ra = S_AXI_ARADDR;
  wire [31:0] status_w = {8'h0, 2'h0, arm_wait_q, evt_q, 1'b0,
                          state_q, 16'(pass_q)};
  logic [31:0] rd_w;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    if (ra == `SCI_A_CTRL)
      rd_w = ctrl_old;
    else if (ra == `SCI_A_MODE)
      rd_w = mode_rd;
    else if (ra == `SCI_A_LOOPS)
      rd_w = {{(32-CNT_W){1'b0}}, loops_q};
    else if (ra == `SCI_A_SEGLEN)
      rd_w = {{(32-CNT_W){1'b0}}, seglen_q};
    else if (ra == `SCI_A_SWIDX)
      rd_w = {13'h0, sw_idx_q};
    else if (ra == `SCI_A_STATUS)
      rd_w = status_w;
    else if (ra == `SCI_A_INDEX)
      rd_w = {13'h0, idx_q};
    else
    begin
      rd_w   = 32'h0;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= `SCI_RESP_OK;
    end
    else if (S_AXI_ARVALID && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_w;
      rresp_q  <= rd_hit ? `SCI_RESP_OK : `SCI_RESP_ERR;
    end
    else if (rvalid_q && S_AXI_RREADY)
      rvalid_q <= 1'b0;
  end

  // Two-stage synchroniser for the index port; load edges seen past the second stage, trigger edges on the raw input
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      port_s1_q   <= '0;
      port_s2_q   <= '0;
      load_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end
    else
    begin
      port_s1_q   <= {IDX_SEL, IDX_LOAD, IDX_DATA};
      port_s2_q   <= port_s1_q;
      load_prev_q <= port_s2_q.load;
      trig_prev_q <= TRIG_GATE_IN;
    end
  end

  // Strobe edge and trigger/gate/event merge with software
  wire load_rise = port_s2_q.load && !load_prev_q;
  wire hi_load   = load_rise && port_s2_q.sel;
  wire lo_load   = load_rise && !port_s2_q.sel;
  wire trig_ev   = (TRIG_GATE_IN && !trig_prev_q) || sw_trig;
  wire gate_lvl  = TRIG_GATE_IN || sw_ena_q;
  wire gate_fall = !TRIG_GATE_IN && trig_prev_q;
  wire ena_lvl   = TRIG_GATE_IN || sw_ena_q;
  wire evt_in    = EVENT_IN || sw_evt;
  wire hw_take   = lo_load && !hw_dis_q && !sw_prec_q;

  // Index holders; only a lower-part load or a software index write passes the index on
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      hi_q      <= '0;
      lo_q      <= '0;
      hw_idx_q  <= '0;
      idx_q     <= '0;
      idx_stb_q <= 1'b0;
      sw_prec_q <= 1'b0;
    end
    else
    begin
      idx_stb_q <= 1'b0;
      if (hi_load)
        hi_q <= port_s2_q.data[`SCI_HI_W-1:0];
      if (lo_load)
      begin
        lo_q     <= port_s2_q.data;
        hw_idx_q <= {hi_q, port_s2_q.data};
      end
      if (wr_swi)
      begin
        sw_prec_q <= 1'b1;
        idx_q     <= swi_new[`SCI_IDX_W-1:0];
        idx_stb_q <= 1'b1;
      end
      else if (hw_take)
      begin
        idx_q     <= {hi_q, port_s2_q.data};
        idx_stb_q <= 1'b1;
      end
      if (wr_ctrl && ctrl_new[`SCI_B_HWDIS])
        sw_prec_q <= 1'b0;
    end
  end

  // Segment timing helpers
  wire start_ok  = !mode_q.armed || ena_lvl;
  wire seg_end   = (state_q == SCI_ST_PLAY) &&
                   (pos_q == seglen_q - CNT_W'(1));
  wire last_pass = (pass_q == loops_q - CNT_W'(1));
  wire trig_go   = (mode_q.tmode == SCI_TRG_GATE) ?
                   (gate_lvl && !trig_prev_q) : trig_ev;
  wire consume   = evt_q &&
                   (((state_q == SCI_ST_WEVT)) ||
                    (seg_end && mode_q.adv == SCI_ADV_COND));

  // Sequencer state machine; stop wins over everything but reset
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      state_q     <= SCI_ST_PROG;
      pos_q       <= '0;
      pass_q      <= '0;
      arm_wait_q  <= 1'b0;
      gate_stop_q <= 1'b0;
    end
    else if (sw_stop)
    begin
      state_q <= SCI_ST_PROG;
      pos_q   <= '0;
    end
    else
    begin
      case (state_q)
        SCI_ST_PROG:
          if (sw_run)
          begin
            state_q    <= SCI_ST_OFFS;
            arm_wait_q <= mode_q.armed;
            pass_q     <= '0;
            pos_q      <= '0;
          end
        SCI_ST_OFFS, SCI_ST_HOLD:
          if (mode_q.tmode == SCI_TRG_CONT && state_q == SCI_ST_OFFS)
            state_q <= SCI_ST_PLAY;
          else if (mode_q.tmode != SCI_TRG_CONT && trig_go && start_ok)
          begin
            state_q     <= SCI_ST_PLAY;
            pass_q      <= '0;
            pos_q       <= '0;
            gate_stop_q <= 1'b0;
          end
        SCI_ST_PLAY:
        begin
          // Triggers here fall through unused
          if (mode_q.tmode == SCI_TRG_GATE && gate_fall)
          begin
            gate_stop_q <= 1'b1;
            pass_q      <= '0;
          end
          if (arm_wait_q && mode_q.tmode == SCI_TRG_CONT && ena_lvl)
            arm_wait_q <= 1'b0;
          pos_q <= seg_end ? '0 : pos_q + CNT_W'(1);
          if (seg_end)
          begin
            if (arm_wait_q && mode_q.tmode == SCI_TRG_CONT)
              pass_q <= '0;
            else if (mode_q.tmode == SCI_TRG_CONT)
              pass_q <= last_pass ? '0 : pass_q + CNT_W'(1);
            else if (mode_q.tmode == SCI_TRG_GATE && !gate_stop_q)
              pass_q <= '0;
            else if (mode_q.adv == SCI_ADV_COND)
              pass_q <= '0;
            else if (mode_q.adv == SCI_ADV_SNGL)
            begin
              state_q <= SCI_ST_WEVT;
              pass_q  <= pass_q + CNT_W'(1);
            end
            else
            begin
              // Last pass counted too, so status shows all loops done
              pass_q <= pass_q + CNT_W'(1);
              if (last_pass && mode_q.adv == SCI_ADV_REPT)
                state_q <= SCI_ST_WEVT;
              else if (last_pass)
                state_q <= SCI_ST_HOLD;
            end
          end
        end
        SCI_ST_WEVT:
          if (evt_q)
            state_q <= (mode_q.adv == SCI_ADV_SNGL && pass_q != loops_q) ?
                       SCI_ST_PLAY : SCI_ST_HOLD;
        default:
          state_q <= SCI_ST_PROG;
      endcase
    end
  end

  // Event latch; a new event in the consuming cycle is kept
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      evt_q <= 1'b0;
    else if (evt_in)
      evt_q <= 1'b1;
    else if (consume)
      evt_q <= 1'b0;
  end

  // Output selection, registered
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
      out_sel_q <= SCI_OUT_OFFSET;
    else if (state_q == SCI_ST_PLAY)
      out_sel_q <= SCI_OUT_SAMPLE;
    else if (state_q == SCI_ST_WEVT || state_q == SCI_ST_HOLD)
      out_sel_q <= SCI_OUT_LAST;
    else
      out_sel_q <= SCI_OUT_OFFSET;
  end

  assign SEQ_INDEX     = idx_q;
  assign SEQ_INDEX_STB = idx_stb_q;
  assign OUT_SEL       = out_sel_q;
  assign OFFSET_CODE   = MID_CODE;
  assign SEG_POS       = pos_q;
  assign RUNNING       = (state_q != SCI_ST_PROG);
endmodule
`default_nettype wire

// File: testbench/sci_ctrl_inputs_monitor.sv
`include "sci_defines.svh"
`default_nettype none
module sci_ctrl_inputs_monitor
  import sci_pkg::*;
#(
  parameter int DAC_BITS = 14,
  parameter int CNT_W    = 16
)(
  input wire logic                MCLK,
  input wire logic                SYS_RST,
  input wire logic [7:0]          S_AXI_AWADDR,
  input wire logic                S_AXI_AWVALID,
  input wire logic                S_AXI_AWREADY,
  input wire logic [31:0]         S_AXI_WDATA,
  input wire logic [3:0]          S_AXI_WSTRB,
  input wire logic                S_AXI_WVALID,
  input wire logic                S_AXI_WREADY,
  input wire logic [12:0]         IDX_DATA,
  input wire logic                IDX_SEL,
  input wire logic                IDX_LOAD,
  input wire logic [18:0]         SEQ_INDEX,
  input wire logic                SEQ_INDEX_STB,
  input wire logic [1:0]          OUT_SEL,
  input wire logic [DAC_BITS-1:0] OFFSET_CODE,
  input wire logic                RUNNING
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [DAC_BITS-1:0] MID = DAC_BITS'(((1 << DAC_BITS) - 1) >> 1);
  logic ctrl_wr;

  // Control word taken with both halves in one edge, low lane enabled
  assign ctrl_wr = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
                   && S_AXI_WREADY && S_AXI_WSTRB[0]
                   && (S_AXI_AWADDR == `SCI_A_CTRL);

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  AST_STB_PULSE: assert property (
    SEQ_INDEX_STB |=> !SEQ_INDEX_STB)
    else $error("index strobe wider than one cycle");
  AST_UPPER_QUIET: assert property (
    $rose(IDX_LOAD) && IDX_SEL |=> !SEQ_INDEX_STB [*6])
    else $error("upper part load handed an index on");
  AST_LOWER_BITS: assert property (
    SEQ_INDEX_STB && IDX_LOAD && !IDX_SEL |-> SEQ_INDEX[12:0] == IDX_DATA)
    else $error("lower index bits differ from data lines");
  AST_OFFSET_MID: assert property (
    OFFSET_CODE == MID)
    else $error("offset code not mid-scale");
  AST_START_OFFSET: assert property (
    $rose(RUNNING) |-> OUT_SEL == SCI_OUT_OFFSET ##1 OUT_SEL == SCI_OUT_OFFSET)
    else $error("run did not begin with offset");
  AST_IDLE_QUIET: assert property (
    !RUNNING |=> OUT_SEL == SCI_OUT_OFFSET)
    else $error("output not offset while idle");
  AST_STOP_NOW: assert property (
    ctrl_wr && S_AXI_WDATA[`SCI_B_STOP] |-> ##[1:3] !RUNNING)
    else $error("stop did not abort");
  AST_RUN_GO: assert property (
    ctrl_wr && S_AXI_WDATA[`SCI_B_RUN] && !S_AXI_WDATA[`SCI_B_STOP]
    && !RUNNING |-> ##[1:3] RUNNING)
    else $error("run command ignored");

  // Main scenarios reached
  COV_STB: cover property (SEQ_INDEX_STB);
  COV_HOLD: cover property (OUT_SEL == SCI_OUT_LAST);
  COV_STOP: cover property (RUNNING ##1 !RUNNING);
endmodule

bind sci_ctrl_inputs sci_ctrl_inputs_monitor #(
  .DAC_BITS(DAC_BITS),
  .CNT_W   (CNT_W)
) u_mon (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .IDX_DATA(IDX_DATA), .IDX_SEL(IDX_SEL), .IDX_LOAD(IDX_LOAD),
  .SEQ_INDEX(SEQ_INDEX), .SEQ_INDEX_STB(SEQ_INDEX_STB), .OUT_SEL(OUT_SEL),
  .OFFSET_CODE(OFFSET_CODE), .RUNNING(RUNNING)
);
`default_nettype wire

// File: testbench/sci_idx_source.sv
`default_nettype none
module sci_idx_source
  import sci_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        wide,
  input  wire logic [12:0] hi_part,
  input  wire logic [12:0] lo_part,
  output logic [12:0]      idx_data,
  output logic             idx_sel,
  output logic             idx_load,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ns;

  // One strobe: data held through the whole load time, then scrambled
  task xfer(input logic s, input logic [12:0] d);
    begin
      idx_sel <= s;
      idx_data <= d;
      idx_load <= 1'b1;
      repeat (7) @(posedge clk);
      idx_load <= 1'b0;
      idx_sel <= 1'b0;
      idx_data <= ~d;
      repeat (7) @(posedge clk);
    end
  endtask

  // Upper part first, then lower; padded so updates stay under 1 MHz
  initial
  begin
    idx_data = 13'h0000;
    idx_sel = 1'b0;
    idx_load = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk);
      if (req)
      begin
        busy <= 1'b1;
        if (wide) xfer(1'b1, hi_part);
        xfer(1'b0, lo_part);
        repeat (wide ? 22 : 36) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/sci_ctrl_inputs_bench.sv
`include "sci_defines.svh"
`default_nettype none
module sci_ctrl_inputs_bench
  import sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, seq_index_stb;
  logic        running, trig, evt, req, wide, idx_sel, idx_load, busy;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, out_sel;
  logic [12:0] hi, lo, idx_data;
  logic [15:0] seg_pos;
  logic [18:0] seq_index;
  logic [13:0] offset_code;
  int          fail_count, samples_checked, cycles, stb_count;

  sci_ctrl_inputs DUT (
    .MCLK(mclk), .SYS_RST(sys_rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .IDX_DATA(idx_data), .IDX_SEL(idx_sel),
    .IDX_LOAD(idx_load), .TRIG_GATE_IN(trig), .EVENT_IN(evt),
    .SEQ_INDEX(seq_index), .SEQ_INDEX_STB(seq_index_stb), .OUT_SEL(out_sel),
    .OFFSET_CODE(offset_code), .SEG_POS(seg_pos), .RUNNING(running));

  sci_idx_source u_src (
    .clk(mclk), .req(req), .wide(wide), .hi_part(hi), .lo_part(lo),
    .idx_data(idx_data), .idx_sel(idx_sel), .idx_load(idx_load),
    .busy(busy));

  task close_out;
    begin
      if (fail_count == 0 && samples_checked > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        fail_count++;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask

  // Both write halves offered together; each dropped once taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ap, wp;
    begin
      ap = 1'b1;
      wp = 1'b1;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
        @(posedge mclk);
        if (awready) ap = 1'b0;
        if (wready) wp = 1'b0;
        awvalid <= ap;
        wvalid <= wp;
        if (bvalid) break;
      end
      resp = bresp;
      bready <= 1'b0;
    end
  endtask

  task axi_rd(input logic [7:0] a);
    begin
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
        @(posedge mclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) break;
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    begin
      axi_rd(a);
      chk_word(rd, exp);
    end
  endtask

  task wait_out(input logic [1:0] v, input int n);
    int i;
    begin
      for (i = 0; i < n; i++)
      begin
        @(posedge mclk);
        if (out_sel === v) break;
      end
      chk_word({30'h0, out_sel}, {30'h0, v});
    end
  endtask

  task send_idx(input logic w, input logic [12:0] h, input logic [12:0] l);
    begin
      @(posedge mclk);
      req <= 1'b1;
      wide <= w;
      hi <= h;
      lo <= l;
      @(posedge mclk);
      req <= 1'b0;
      @(posedge mclk);
      while (busy) @(posedge mclk);
    end
  endtask

  task pulse_in(input logic ev);
    begin
      @(posedge mclk);
      if (ev) evt <= 1'b1;
      else trig <= 1'b1;
      @(posedge mclk);
      evt <= 1'b0;
      trig <= 1'b0;
    end
  endtask

  task stop_run;
    begin
      axi_wr(`SCI_A_CTRL, 32'h2);
      repeat (3) @(posedge mclk);
      chk_word({31'h0, running}, 32'h0);
      chk_word({30'h0, out_sel}, 32'h0);
    end
  endtask

  // Reset values, unmapped read, refused write to a read-only word
  task t_regs;
    begin
      rd_chk(`SCI_A_LOOPS, 32'h1);
      rd_chk(`SCI_A_SEGLEN, 32'h10);
      rd_chk(`SCI_A_MODE, 32'h0);
      rd_chk(8'h1c, 32'h0);
      chk_word({30'h0, resp}, {30'h0, `SCI_RESP_ERR});
      axi_wr(`SCI_A_STATUS, 32'hffff);
      chk_word({30'h0, resp}, {30'h0, `SCI_RESP_ERR});
      axi_wr(`SCI_A_LOOPS, 32'h2);
      axi_wr(`SCI_A_SEGLEN, 32'h4);
      rd_chk(`SCI_A_LOOPS, 32'h2);
    end
  endtask

  // Upper part carries junk in bits 12..6 that must be dropped
  task t_index;
    int c0;
    begin
      c0 = stb_count;
      send_idx(1'b1, 13'h1f55, 13'h0abc);
      chk_word({13'h0, seq_index}, {13'h0, 6'h15, 13'h0abc});
      chk_word(32'(stb_count - c0), 32'h1);
      send_idx(1'b0, 13'h0000, 13'h1234);
      chk_word({13'h0, seq_index}, {13'h0, 6'h15, 13'h1234});
    end
  endtask

  task t_sw;
    begin
      axi_wr(`SCI_A_SWIDX, 32'h54321);
      repeat (3) @(posedge mclk);
      chk_word({13'h0, seq_index}, 32'h54321);
      send_idx(1'b0, 13'h0000, 13'h0777);
      chk_word({13'h0, seq_index}, 32'h54321);
      axi_wr(`SCI_A_CTRL, 32'h20);
      send_idx(1'b0, 13'h0000, 13'h0999);
      chk_word({13'h0, seq_index}, 32'h54321);
      axi_wr(`SCI_A_CTRL, 32'h0);
      send_idx(1'b0, 13'h0000, 13'h0777);
      chk_word({13'h0, seq_index}, {13'h0, 6'h15, 13'h0777});
    end
  endtask

  task t_cont;
    begin
      axi_wr(`SCI_A_MODE, 32'h0);
      chk_word({31'h0, running}, 32'h0);
      axi_wr(`SCI_A_CTRL, 32'h1);
      chk_word({30'h0, out_sel}, 32'h0);
      wait_out(SCI_OUT_SAMPLE, 8);
      repeat (40) @(posedge mclk);
      chk_word({30'h0, out_sel}, 32'h1);
      chk_word({18'h0, offset_code}, 32'h1fff);
      stop_run;
    end
  endtask

  // Triggered arbitrary playback in every advancement mode
  task t_trig;
    int m;
    logic [2:0] st_exp [4];
    begin
      st_exp = '{3'h4, 3'h2, 3'h3, 3'h3};
      for (m = 0; m < 4; m++)
      begin
        axi_wr(`SCI_A_MODE, {26'h0, m[1:0], 4'h1});
        axi_wr(`SCI_A_CTRL, 32'h1);
        repeat (12) @(posedge mclk);
        chk_word({30'h0, out_sel}, 32'h0);
        pulse_in(1'b0);
        wait_out(SCI_OUT_SAMPLE, 8);
        repeat (30) @(posedge mclk);
        axi_rd(`SCI_A_STATUS);
        chk_word({29'h0, rd[18:16]}, {29'h0, st_exp[m]});
        if (m == 0) chk_word({30'h0, out_sel}, 32'h2);
        pulse_in(1'b1);
        repeat (3) @(posedge mclk);
        if (m == 0)
          rd_chk(`SCI_A_STATUS, {11'h0, 2'h2, 3'h4, 16'h2});
        if (m == 2) rd_chk(`SCI_A_STATUS, {13'h0, 3'h4, 16'h2});
        if (m == 3) wait_out(SCI_OUT_SAMPLE, 10);
        stop_run;
      end
    end
  endtask

  // Gate level starts play; its fall ends play after the loop count
  task t_gate;
    begin
      axi_wr(`SCI_A_MODE, 32'h2);
      axi_wr(`SCI_A_CTRL, 32'h1);
      repeat (4) @(posedge mclk);
      chk_word({30'h0, out_sel}, 32'h0);
      trig <= 1'b1;
      wait_out(SCI_OUT_SAMPLE, 8);
      repeat (20) @(posedge mclk);
      chk_word({30'h0, out_sel}, 32'h1);
      trig <= 1'b0;
      wait_out(SCI_OUT_LAST, 20);
      chk_word({16'h0, seg_pos}, 32'h0);
      stop_run;
    end
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Bounded run; a hang ends in the closing report
  always @(posedge mclk)
  begin
    cycles++;
    if (seq_index_stb === 1'b1) stb_count++;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out;
    end
  end

  initial
  begin
    {sys_rst, wstrb} = 5'h1f;
    {awvalid, wvalid, bready, arvalid, rready, trig, evt, req, wide} = '0;
    {awaddr, araddr, wdata, hi, lo} = '0;
    {fail_count, samples_checked, cycles, stb_count} = '0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs;
    t_index;
    t_sw;
    t_cont;
    t_trig;
    t_gate;
    close_out;
  end
endmodule
`default_nettype wire
